/* shared/hcc_pkg.sv */
// Package with register map, field positions, timing constants and states of the chuck control
package hcc_pkg;

    // ********************
    // Register map (word index on the plain port)
    // ********************
    localparam logic [3:0] ADDR_OPTION = 4'h0;
    localparam logic [3:0] ADDR_INTERLOCK = 4'h1;
    localparam logic [3:0] ADDR_PULSE_TIME = 4'h2;
    localparam logic [3:0] ADDR_CHECK_TIME = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_COMMAND = 4'h5;

    // ********************
    // Field positions
    // ********************
    localparam int BIT_CHUCK_FUNCTION_DISABLE = 7;
    localparam int BIT_INNER_CHUCK_SELECT = 6;
    localparam int BIT_RESPONSE_CHECK_ENABLE = 5;
    localparam int BIT_PULSE_OUTPUT_SELECT = 3;
    localparam int BIT_FOOT_SWITCH_DISABLE = 1;
    localparam int BIT_SPINDLE_INTERLOCK_DISABLE = 5;
    localparam int BIT_CONTINUOUS_CHECK_ENABLE = 4;

    // Command register bits
    localparam int CMD_CLAMP = 0;
    localparam int CMD_RELEASE = 1;
    localparam int CMD_CANCEL = 2;
    localparam int CMD_CLEAR_ALARM = 3;

    // ********************
    // Reset values
    // ********************
    localparam logic [7:0] OPTION_RESET = 8'h00;
    localparam logic [7:0] INTERLOCK_RESET = 8'h00;
    localparam logic [15:0] PULSE_TIME_RESET = 16'h000a;
    localparam logic [15:0] CHECK_TIME_RESET = 16'h0064;

    // ********************
    // Timing: time registers count milliseconds
    // ********************
    localparam int CLOCK_HZ = 40000000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLOCK_HZ / 1000 * TICK_MS;
    localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

    typedef enum logic [1:0] {
        HCC_IDLE = 2'b00,
        HCC_DRIVE = 2'b01,
        HCC_WAIT = 2'b11
    } hcc_state_e;

endpackage

/* verilog/hcc_tick.sv */
// Millisecond tick divider for the chuck control timers
`timescale 1ns/1ps

module hcc_tick
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    output logic tick_o
);

    logic [15:0] count_reg;

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i || count_reg == hcc_pkg::TICK_LAST)
        begin
            count_reg <= 16'h0000;
        end
        else
        begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            tick_o <= 1'b0;
        end
        else
        begin
            tick_o <= (count_reg == hcc_pkg::TICK_LAST);
        end
    end

endmodule

/* verilog/hcc_chuck_ctrl.sv */
// Hydraulic chuck control: commands, foot switch, valve outputs, response check and interlock
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps

// Behaviour
// R1: Chuck function only when disable bit is 0
// R2: Spindle interlock active when its bit is 0
// R3: Continuous check bit enables ongoing monitoring
// R4: Chuck type bit selects outer or inner
// R5: Response check bit requires in-position confirmation
// R6: Output style bit selects level or pulse
// R7: Foot switch accepted only when bit is 0
// R8: Without check, drive output and finish at once
// R9: Clamp done: clamp input low, release high
// R10: Release done: release input low, clamp high
// R11: Inner mode swaps the two output pins
// R12: Each foot press toggles clamp and release
// R13: Foot pressed on entering jog/auto alarms
// R14: Cancel withdraws both chuck outputs
// R15: Manual commands accepted in jog mode
// R16: Interlock refuses chuck while spindle runs
// R17: After reset chuck assumed released
// R18: Failed or interrupted operation blocks program start
// R19: Abnormal release in machining stops program, spindle
// R20: Level output holds until next command
// R21: Times measured by counter from programmed values

module hcc_chuck_ctrl
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    input wire logic jog_mode_i,
    input wire logic auto_mode_i,
    input wire logic machining_i,
    input wire logic spindle_running_i,
    input wire logic estop_i,
    input wire logic foot_switch_i,
    input wire logic clamp_in_position_input_i,
    input wire logic release_in_position_input_i,
    input wire logic spindle_start_req_i,
    output logic clamp_command_output_o,
    output logic release_command_output_o,
    output logic chuck_signal_cancel_o,
    output logic busy_o,
    output logic spindle_start_allow_o,
    output logic program_start_block_o,
    output logic program_stop_o,
    output logic spindle_off_o,
    output logic alarm_o
);

    // ********************
    // Registers
    // ********************
    logic [7:0] chuck_option_settings_reg;
    logic [7:0] interlock_check_settings_reg;
    logic [15:0] pulse_time_reg;
    logic [15:0] check_time_reg;
    logic clamped_reg;
    logic target_clamp_reg;
    logic unconfirmed_reg;
    logic response_ok_reg;
    logic drive_clamp_reg;
    logic drive_release_reg;
    logic pulse_active_reg;
    logic [15:0] pulse_count_reg;
    logic [15:0] check_count_reg;
    logic foot_prev_reg;
    logic mode_prev_reg;
    logic clamp_timeout_reg;
    logic release_timeout_reg;
    logic interlock_alarm_reg;
    logic foot_alarm_reg;
    logic abnormal_release_reg;
    hcc_pkg::hcc_state_e state_reg;

    logic tick;
    logic func_on, inner_sel, check_en, pulse_sel, foot_en, interlock_en, cont_en;
    logic cmd_wr, cmd_clamp, cmd_release, cmd_cancel, cmd_clear;
    logic foot_press, foot_accepted, op_req, op_refused, op_start, op_clamp;
    logic mode_enter, in_pos_ok, check_timeout;

    hcc_tick tick_div
    (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .tick_o(tick)
    );

    assign func_on = !chuck_option_settings_reg[hcc_pkg::BIT_CHUCK_FUNCTION_DISABLE]; // see R1
    assign inner_sel = chuck_option_settings_reg[hcc_pkg::BIT_INNER_CHUCK_SELECT]; // see R4
    assign check_en = chuck_option_settings_reg[hcc_pkg::BIT_RESPONSE_CHECK_ENABLE]; // see R5
    assign pulse_sel = chuck_option_settings_reg[hcc_pkg::BIT_PULSE_OUTPUT_SELECT]; // see R6
    assign foot_en = !chuck_option_settings_reg[hcc_pkg::BIT_FOOT_SWITCH_DISABLE]; // see R7
    assign interlock_en =
        !interlock_check_settings_reg[hcc_pkg::BIT_SPINDLE_INTERLOCK_DISABLE]; // see R2
    assign cont_en = interlock_check_settings_reg[hcc_pkg::BIT_CONTINUOUS_CHECK_ENABLE]; // see R3

    // ********************
    // Command decode
    // ********************
    assign cmd_wr = wr_i && addr_i == hcc_pkg::ADDR_COMMAND;
    // Manual commands only in jog mode
    assign cmd_clamp = cmd_wr && wdata_i[hcc_pkg::CMD_CLAMP] && jog_mode_i; // see R15
    assign cmd_release = cmd_wr && wdata_i[hcc_pkg::CMD_RELEASE] && jog_mode_i; // see R15
    assign cmd_cancel = cmd_wr && wdata_i[hcc_pkg::CMD_CANCEL] && func_on; // see R14
    assign cmd_clear = cmd_wr && wdata_i[hcc_pkg::CMD_CLEAR_ALARM];

    // Foot switch is dead during automatic run
    assign foot_press = foot_switch_i && !foot_prev_reg;
    assign foot_accepted = foot_press && foot_en && !auto_mode_i; // see R7 R12

    assign op_req = func_on && (cmd_clamp || cmd_release || foot_accepted); // see R1
    assign op_refused = op_req && interlock_en && spindle_running_i; // see R16
    assign op_start = op_req && !op_refused && !estop_i;
    // Foot press toggles; first press after reset clamps since state starts released
    assign op_clamp = foot_accepted ? !clamped_reg : cmd_clamp; // see R12 R17

    assign in_pos_ok = target_clamp_reg ?
        (!clamp_in_position_input_i && release_in_position_input_i) : // see R9
        (!release_in_position_input_i && clamp_in_position_input_i); // see R10
    assign check_timeout = check_count_reg == 16'h0000 && tick;
    assign mode_enter = (jog_mode_i || auto_mode_i) && !mode_prev_reg;

    // ********************
    // Register writes
    // ********************
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            chuck_option_settings_reg <= hcc_pkg::OPTION_RESET;
            interlock_check_settings_reg <= hcc_pkg::INTERLOCK_RESET;
            pulse_time_reg <= hcc_pkg::PULSE_TIME_RESET;
            check_time_reg <= hcc_pkg::CHECK_TIME_RESET;
        end
        else if (wr_i)
        begin
            case (addr_i)
                hcc_pkg::ADDR_OPTION: chuck_option_settings_reg <= wdata_i[7:0];
                hcc_pkg::ADDR_INTERLOCK: interlock_check_settings_reg <= wdata_i[7:0];
                hcc_pkg::ADDR_PULSE_TIME: pulse_time_reg <= wdata_i;
                hcc_pkg::ADDR_CHECK_TIME: check_time_reg <= wdata_i;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            rdata_o <= 16'h0000;
        end
        else if (rd_i)
        begin
            case (addr_i)
                hcc_pkg::ADDR_OPTION: rdata_o <= {8'h00, chuck_option_settings_reg};
                hcc_pkg::ADDR_INTERLOCK: rdata_o <= {8'h00, interlock_check_settings_reg};
                hcc_pkg::ADDR_PULSE_TIME: rdata_o <= pulse_time_reg;
                hcc_pkg::ADDR_CHECK_TIME: rdata_o <= check_time_reg;
                hcc_pkg::ADDR_STATUS: rdata_o <= {5'h00, busy_o, abnormal_release_reg,
                    foot_alarm_reg, interlock_alarm_reg, release_timeout_reg,
                    clamp_timeout_reg, response_ok_reg, unconfirmed_reg,
                    chuck_signal_cancel_o, target_clamp_reg, clamped_reg};
                default: rdata_o <= 16'h0000;
            endcase
        end
        else
        begin
            rdata_o <= 16'h0000;
        end
    end

    // ********************
    // Operation sequencer
    // ********************
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i || estop_i)
        begin
            state_reg <= hcc_pkg::HCC_IDLE;
        end
        else
        begin
            case (state_reg)
                hcc_pkg::HCC_IDLE:
                begin
                    if (op_start)
                    begin
                        state_reg <= check_en ? hcc_pkg::HCC_WAIT : hcc_pkg::HCC_IDLE; // see R8
                    end
                end
                hcc_pkg::HCC_WAIT:
                begin
                    if (cmd_cancel || in_pos_ok || check_timeout)
                    begin
                        state_reg <= hcc_pkg::HCC_IDLE;
                    end
                end
                default: state_reg <= hcc_pkg::HCC_IDLE;
            endcase
        end
    end

    assign busy_o = state_reg == hcc_pkg::HCC_WAIT;

    // Response timer loaded from programmed check time, counts ms ticks
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            check_count_reg <= 16'h0000;
        end
        else if (op_start && state_reg == hcc_pkg::HCC_IDLE)
        begin
            check_count_reg <= check_time_reg; // see R21
        end
        else if (busy_o && tick && check_count_reg != 16'h0000)
        begin
            check_count_reg <= check_count_reg - 16'h0001; // see R21
        end
    end

    // Chuck position: power-on and emergency stop assume released
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i || estop_i)
        begin
            clamped_reg <= 1'b0; // see R17
            target_clamp_reg <= 1'b0;
        end
        else if (op_start && state_reg == hcc_pkg::HCC_IDLE)
        begin
            target_clamp_reg <= op_clamp;
            clamped_reg <= op_clamp;
        end
    end

    // Unconfirmed until a clean completion; estop during a wait interrupts the operation, reset clears the flag
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            unconfirmed_reg <= 1'b0;
            response_ok_reg <= 1'b0;
        end
        else if ((estop_i && busy_o) || (busy_o && ((check_timeout && !in_pos_ok) || cmd_cancel)))
        begin
            unconfirmed_reg <= 1'b1; // see R18
            response_ok_reg <= 1'b0; // see R5
        end
        else if (busy_o && in_pos_ok)
        begin
            unconfirmed_reg <= 1'b0;
            response_ok_reg <= 1'b1; // see R5
        end
        else if (op_start && !check_en && state_reg == hcc_pkg::HCC_IDLE)
        begin
            unconfirmed_reg <= 1'b0; // see R8
        end
    end

    assign program_start_block_o = unconfirmed_reg || busy_o; // see R18

    // ********************
    // Valve outputs
    // ********************
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i || estop_i)
        begin
            drive_clamp_reg <= 1'b0;
            drive_release_reg <= 1'b0;
            pulse_active_reg <= 1'b0;
            pulse_count_reg <= 16'h0000;
            chuck_signal_cancel_o <= 1'b0;
        end
        else if (cmd_cancel)
        begin
            drive_clamp_reg <= 1'b0; // see R14
            drive_release_reg <= 1'b0; // see R14
            pulse_active_reg <= 1'b0;
            chuck_signal_cancel_o <= 1'b1;
        end
        else if (op_start && state_reg == hcc_pkg::HCC_IDLE)
        begin
            drive_clamp_reg <= op_clamp; // see R20
            drive_release_reg <= !op_clamp; // see R20
            pulse_active_reg <= pulse_sel; // see R6
            pulse_count_reg <= pulse_time_reg; // see R21
            chuck_signal_cancel_o <= 1'b0;
        end
        else if (pulse_active_reg && tick)
        begin
            if (pulse_count_reg <= 16'h0001)
            begin
                drive_clamp_reg <= 1'b0; // see R6
                drive_release_reg <= 1'b0;
                pulse_active_reg <= 1'b0;
            end
            pulse_count_reg <= pulse_count_reg - 16'h0001;
        end
    end

    // Inner chuck swaps the pins
    assign clamp_command_output_o = inner_sel ? drive_release_reg : drive_clamp_reg; // see R11
    assign release_command_output_o = inner_sel ? drive_clamp_reg : drive_release_reg; // see R11

    // ********************
    // Alarms and supervision
    // ********************
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            foot_prev_reg <= 1'b0;
            mode_prev_reg <= 1'b0;
        end
        else
        begin
            foot_prev_reg <= foot_switch_i;
            mode_prev_reg <= jog_mode_i || auto_mode_i;
        end
    end

    // Sticky alarms: a new event wins over a clear in the same cycle
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            clamp_timeout_reg <= 1'b0;
            release_timeout_reg <= 1'b0;
            interlock_alarm_reg <= 1'b0;
            foot_alarm_reg <= 1'b0;
            abnormal_release_reg <= 1'b0;
        end
        else
        begin
            clamp_timeout_reg <= (busy_o && check_timeout && !in_pos_ok && target_clamp_reg)
                || (clamp_timeout_reg && !cmd_clear); // see R9
            release_timeout_reg <= (busy_o && check_timeout && !in_pos_ok && !target_clamp_reg)
                || (release_timeout_reg && !cmd_clear); // see R10
            interlock_alarm_reg <= op_refused
                || (func_on && interlock_en && spindle_start_req_i && !clamped_reg)
                || (interlock_alarm_reg && !cmd_clear); // see R16
            foot_alarm_reg <= (func_on && foot_en && mode_enter && foot_switch_i)
                || (foot_alarm_reg && !cmd_clear); // see R13
            abnormal_release_reg <= (func_on && cont_en && machining_i && clamped_reg
                && !busy_o && !(!clamp_in_position_input_i && release_in_position_input_i))
                || (abnormal_release_reg && !cmd_clear); // see R19
        end
    end

    assign spindle_start_allow_o = !(func_on && interlock_en && !clamped_reg); // see R16
    assign program_stop_o = abnormal_release_reg; // see R19
    assign spindle_off_o = abnormal_release_reg; // see R19
    assign alarm_o = clamp_timeout_reg || release_timeout_reg || interlock_alarm_reg
        || foot_alarm_reg || abnormal_release_reg;

    // ********************
    // Checks
    // ********************
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    ignore_disabled_a: assert property (!func_on |-> !op_start) // see R1
        else $error("chuck operation started while disabled");
    interlock_refuse_a: assert property
        (op_req && interlock_en && spindle_running_i |=> interlock_alarm_reg) // see R16
        else $error("running spindle did not refuse chuck");
    no_check_done_a: assert property
        (op_start && !busy_o && !check_en && !estop_i |=> !busy_o) // see R8
        else $error("operation waited without response check");
    inner_swap_a: assert property
        (inner_sel && drive_clamp_reg |-> release_command_output_o && !clamp_command_output_o)
        else $error("inner chuck pins not swapped"); // see R11
    cancel_outputs_a: assert property
        (cmd_cancel && !estop_i |=> !clamp_command_output_o && !release_command_output_o)
        else $error("cancel left an output on"); // see R14
    level_hold_a: assert property
        (!pulse_sel && drive_clamp_reg && !cmd_cancel && !op_start && !estop_i
        |=> drive_clamp_reg) // see R20
        else $error("level output dropped without command");
    timeout_alarm_a: assert property
        (busy_o && check_timeout && !in_pos_ok && target_clamp_reg && !estop_i
        |=> clamp_timeout_reg && unconfirmed_reg) // see R9
        else $error("clamp timeout not flagged");
    release_done_a: assert property
        (busy_o && !target_clamp_reg && in_pos_ok && !estop_i && !cmd_cancel
        |=> !busy_o && response_ok_reg)
        else $error("release completion missed"); // see R10
    foot_mode_a: assert property
        (func_on && foot_en && mode_enter && foot_switch_i |=> foot_alarm_reg) // see R13
        else $error("foot switch on mode entry not alarmed");
    abnormal_stop_a: assert property
        (abnormal_release_reg |-> program_stop_o && spindle_off_o) // see R19
        else $error("abnormal release did not stop");

    clamp_cover_c: cover property (op_start && op_clamp ##[1:8] busy_o ##1 in_pos_ok);
    pulse_cover_c: cover property (pulse_active_reg ##1 !pulse_active_reg);
    timeout_cover_c: cover property (busy_o && check_timeout);
    foot_cover_c: cover property (foot_accepted && op_start);

endmodule

/* verification/hcc_valve_model.sv */
// Model of the chuck valve and its two in-position sensors
`timescale 1ns/1ps

module hcc_valve_model
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic clamp_valve_i,
    input wire logic release_valve_i,
    input wire logic respond_i,
    input wire logic [7:0] delay_i,
    output logic clamp_in_pos_o,
    output logic release_in_pos_o
);
    logic want_clamp_reg;
    logic [7:0] wait_reg;
    logic moving;

    // ********************
    // Travel of the jaws
    // ********************
    // Reload only on a change of direction: a held level must not stall the travel
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            want_clamp_reg <= 1'b0;
            wait_reg <= 8'h00;
        end
        else if ((clamp_valve_i && !want_clamp_reg) || (release_valve_i && want_clamp_reg))
        begin
            want_clamp_reg <= clamp_valve_i;
            wait_reg <= delay_i;
        end
        else if (wait_reg != 8'h00)
        begin
            wait_reg <= wait_reg - 8'h01;
        end
    end

    // Both high while travelling or silent: neither pattern shows
    assign moving = !respond_i || (wait_reg != 8'h00);
    assign clamp_in_pos_o = moving || !want_clamp_reg;
    assign release_in_pos_o = moving || want_clamp_reg;
endmodule

/* verification/hcc_chuck_ctrl_bench.sv */
// Self-checking bench of the hydraulic chuck control
`timescale 1ns/1ps

module hcc_chuck_ctrl_bench;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic jog = 1'b1;
    logic mach = 1'b0;
    logic spin = 1'b0;
    logic foot = 1'b0;
    logic respond = 1'b1;
    logic [7:0] delay = 8'h04;
    logic [15:0] rdata;
    logic [15:0] got;
    logic [15:0] wval;
    logic [15:0] rv [4];
    logic clamp_in, release_in, clamp_out, release_out, cancel_out, busy;
    logic allow, block, stop, spin_off, alarm;
    int n_errors = 0;
    int comparisons = 0;
    int i;
    int w;

    always #12.5 clock_i = ~clock_i;

    hcc_chuck_ctrl dut
    (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .addr_i(addr),
        .wdata_i(wdata),
        .wr_i(wr),
        .rd_i(rd),
        .rdata_o(rdata),
        .jog_mode_i(jog),
        .auto_mode_i(1'b0),
        .machining_i(mach),
        .spindle_running_i(spin),
        .estop_i(1'b0),
        .foot_switch_i(foot),
        .clamp_in_position_input_i(clamp_in),
        .release_in_position_input_i(release_in),
        .spindle_start_req_i(1'b0),
        .clamp_command_output_o(clamp_out),
        .release_command_output_o(release_out),
        .chuck_signal_cancel_o(cancel_out),
        .busy_o(busy),
        .spindle_start_allow_o(allow),
        .program_start_block_o(block),
        .program_stop_o(stop),
        .spindle_off_o(spin_off),
        .alarm_o(alarm)
    );

    hcc_valve_model valve
    (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .clamp_valve_i(clamp_out),
        .release_valve_i(release_out),
        .respond_i(respond),
        .delay_i(delay),
        .clamp_in_pos_o(clamp_in),
        .release_in_pos_o(release_in)
    );

    // ********************
    // Tasks and expectations
    // ********************
    function automatic logic [1:0] pins(input logic clamp, input logic inner);
        return (clamp ^ inner) ? 2'b01 : 2'b10;
    endfunction

    task automatic print_verdict;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic chk_pins(input logic [1:0] exp);
        chk("pins", {14'h0000, exp}, {14'h0000, release_out, clamp_out});
    endtask

    task automatic step;
        @(posedge clock_i);
        #1;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock_i);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a);
        @(posedge clock_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock_i);
        rd <= 1'b0;
        #1 got = rdata;
    endtask

    task automatic cmd(input logic [15:0] bits);
        wr_reg(hcc_pkg::ADDR_COMMAND, bits);
        step();
    endtask

    task automatic press;
        @(posedge clock_i);
        foot <= 1'b1;
        repeat (3) @(posedge clock_i);
        foot <= 1'b0;
        repeat (3) @(posedge clock_i);
        #1;
    endtask

    // Bounded wait for busy (sel 1) or the release pin (sel 0) to drop
    task automatic wait_low(input int bound, input int sel);
        w = 0;
        while ((sel ? busy : release_out) === 1'b1 && w < bound)
        begin
            @(posedge clock_i);
            w++;
        end
        #1;
        if (w >= bound)
        begin
            n_errors++;
            print_verdict();
        end
    endtask

    initial
    begin
        repeat (95000) @(posedge clock_i);
        n_errors++;
        print_verdict();
    end

    // ********************
    // Scenarios
    // ********************
    initial
    begin
        rv = '{16'h0000, 16'h0000, 16'h000a, 16'h0064};
        i = $urandom(32'h6f6f);
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'b1;
        for (i = 0; i < 4; i++)
        begin
            rd_reg(4'(i));
            chk("reset value", rv[i], got);
        end
        rd_reg(4'h6);
        chk("unmapped", 16'h0000, got);
        wval = 16'($urandom);
        wr_reg(hcc_pkg::ADDR_PULSE_TIME, wval);
        rd_reg(hcc_pkg::ADDR_PULSE_TIME);
        chk("pulse time", wval, got);
        press();
        chk_pins(pins(1'b1, 1'b0));
        press();
        chk_pins(pins(1'b0, 1'b0));
        chk("allow released", 16'h0000, 16'(allow));
        cmd(16'h0001);
        chk("busy", 16'h0000, 16'(busy));
        repeat (5) step();
        chk_pins(pins(1'b1, 1'b0));
        cmd(16'h0004);
        chk("cancel", 16'h0004, {13'h0000, cancel_out, release_out, clamp_out});
        for (i = 3; i >= 0; i--)
        begin
            wr_reg(hcc_pkg::ADDR_OPTION, {8'h00, 1'b0, i[1], 6'h00});
            cmd(i[0] ? 16'h0001 : 16'h0002);
            chk_pins(pins(i[0], i[1]));
        end
        wr_reg(hcc_pkg::ADDR_OPTION, 16'h0080);
        cmd(16'h0001);
        chk_pins(2'b10);
        wr_reg(hcc_pkg::ADDR_OPTION, 16'h0002);
        press();
        chk_pins(2'b10);
        wr_reg(hcc_pkg::ADDR_OPTION, 16'h0000);
        spin <= 1'b1;
        cmd(16'h0001);
        chk_pins(2'b10);
        chk("interlock alarm", 16'h0001, 16'(alarm));
        cmd(16'h0008);
        chk("cleared", 16'h0000, 16'(alarm));
        wr_reg(hcc_pkg::ADDR_INTERLOCK, 16'h0020);
        cmd(16'h0001);
        chk_pins(2'b01);
        spin <= 1'b0;
        wr_reg(hcc_pkg::ADDR_INTERLOCK, 16'h0000);
        wr_reg(hcc_pkg::ADDR_OPTION, 16'h0020);
        // Even count so the chuck ends clamped for the abnormal release check
        for (i = 0; i < 4; i++)
        begin
            delay <= 8'(3 + $urandom % 20);
            cmd(i[0] ? 16'h0001 : 16'h0002);
            chk("busy wait", 16'h0001, 16'(busy));
            wait_low(200, 1);
            rd_reg(hcc_pkg::ADDR_STATUS);
            chk("response", 16'h0010, got & 16'h0070);
        end
        wr_reg(hcc_pkg::ADDR_INTERLOCK, 16'h0010);
        mach <= 1'b1;
        respond <= 1'b0;
        repeat (3) step();
        chk("abnormal", 16'h0003, {14'h0000, stop, spin_off});
        mach <= 1'b0;
        wr_reg(hcc_pkg::ADDR_INTERLOCK, 16'h0000);
        cmd(16'h0008);
        wr_reg(hcc_pkg::ADDR_PULSE_TIME, 16'h0001);
        wr_reg(hcc_pkg::ADDR_CHECK_TIME, 16'h0001);
        wr_reg(hcc_pkg::ADDR_OPTION, 16'h0028);
        cmd(16'h0002);
        chk_pins(2'b10);
        wait_low(45000, 0);
        chk("pulse short", 16'h0001, 16'(w <= 40001));
        wait_low(85000, 1);
        rd_reg(hcc_pkg::ADDR_STATUS);
        chk("timeout", 16'h0048, got & 16'h0068);
        chk("start block", 16'h0001, 16'(block));
        wr_reg(hcc_pkg::ADDR_OPTION, 16'h0000);
        cmd(16'h0008);
        jog <= 1'b0;
        foot <= 1'b1;
        step();
        jog <= 1'b1;
        repeat (3) step();
        chk("foot alarm", 16'h0001, 16'(alarm));
        foot <= 1'b0;
        print_verdict();
    end
endmodule
